// File: rtl/fault_status_pkg.sv
package fault_status_pkg;

    // register map
    localparam logic [7:0] STATUS_ONE_ADDR = 8'h41;
    localparam logic [7:0] STATUS_TWO_ADDR = 8'h42;
    localparam logic [7:0] STATUS_RESET    = 8'h00;

    // status one bit positions
    localparam int S1_V25_BIT     = 0;
    localparam int S1_CORE_BIT    = 1;
    localparam int S1_V33_BIT     = 2;
    localparam int S1_V50_BIT     = 3;
    localparam int S1_ZONE1_BIT   = 4;
    localparam int S1_ZONE2_BIT   = 5;
    localparam int S1_ZONE3_BIT   = 6;
    localparam int S1_SUMMARY_BIT = 7;

    // status two bit positions
    localparam int S2_V12_BIT     = 0;
    localparam int S2_RSVD_BIT    = 1;
    localparam int S2_STALL_LSB   = 2;
    localparam int S2_DIODE1_BIT  = 6;
    localparam int S2_DIODE2_BIT  = 7;

    // measured supplies in status one, fan count and fan period count width
    localparam int NUM_SUPPLIES   = 4;
    localparam int NUM_FANS       = 4;
    localparam int TACH_WIDTH     = 16;

    typedef logic [7:0] byte_t;

endpackage

// File: rtl/fault_bits_if.sv
`timescale 1ns/1ps
`default_nettype none
// raw fault conditions and the read-clear strobes, shared with the latch
interface fault_bits_if;
    logic [7:0] cond;
    logic       rd_clear;
    logic [7:0] status;
    modport src (output cond, output rd_clear, input status);
    modport lat (input cond, input rd_clear, output status);
endinterface
`default_nettype wire

// File: rtl/sticky_byte.sv
`timescale 1ns/1ps
`default_nettype none
module sticky_byte
    import fault_status_pkg::*;
#(
    parameter byte_t KEEP_MASK = 8'hFF
) (
    // clock and reset
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    // fault bits
    fault_bits_if.lat   bits
);
    byte_t status_reg;
    byte_t status_next;

    // set when present; a read clears only bits whose cause has gone
    assign status_next = ((bits.rd_clear ? (status_reg & bits.cond) : status_reg)
                          | bits.cond) & KEEP_MASK;

    // sticky storage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_reg <= STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    assign bits.status = status_reg;
endmodule
`default_nettype wire

// File: rtl/fault_status_latch.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - out-of-window measurement sets its status bit
// - supplies flag on at-or-below low, above high
// - bit4: remote one temp window, zone one
// - bit5: on-die temp window, zone two
// - bit6: remote two temp, zone three limits
// - bit7 reads one when any status-two bit
// - each fault latched independently
// - set bits hold until register read
// - read clears bits whose fault has gone
// - writes to status registers change nothing
// - 12V flags strictly below low, above high
// - fan stall when period count above minimum
// - diode one fault sets two.6, one.4
// - diode two fault sets two.7, one.6
// - temperature compares are signed eight-bit
module fault_status_latch
    import fault_status_pkg::*;
#(
    parameter int TW = TACH_WIDTH
) (
    // clock and reset
    input  wire logic                        ref_clk_i,
    input  wire logic                        nrst_i,
    // supply readings and limits, 2.5V, core, 3.3V, 5V
    input  wire logic [NUM_SUPPLIES-1:0][7:0] supply_val_i,
    input  wire logic [NUM_SUPPLIES-1:0][7:0] supply_low_i,
    input  wire logic [NUM_SUPPLIES-1:0][7:0] supply_high_i,
    // 12V reading and limits
    input  wire logic [7:0]                  v12_val_i,
    input  wire logic [7:0]                  v12_low_i,
    input  wire logic [7:0]                  v12_high_i,
    // temperatures and limits, signed
    input  wire logic [7:0]                  temp_one_i,
    input  wire logic [7:0]                  temp_die_i,
    input  wire logic [7:0]                  temp_two_i,
    input  wire logic [7:0]                  zone_one_low_i,
    input  wire logic [7:0]                  zone_one_high_i,
    input  wire logic [7:0]                  zone_two_low_i,
    input  wire logic [7:0]                  zone_two_high_i,
    input  wire logic [7:0]                  zone_three_low_i,
    input  wire logic [7:0]                  zone_three_high_i,
    // diode faults
    input  wire logic                        diode_one_fault_i,
    input  wire logic                        diode_two_fault_i,
    // fan period counts and minimum settings
    input  wire logic [NUM_FANS-1:0][TW-1:0] tach_count_i,
    input  wire logic [NUM_FANS-1:0][TW-1:0] tach_min_i,
    // register access
    input  wire logic [7:0]                  reg_addr_i,
    input  wire logic                        reg_rd_i,
    input  wire logic                        reg_wr_i,
    input  wire logic [7:0]                  reg_wdata_i,
    // read data
    output logic [7:0]                       reg_rdata_o,
    output logic                             reg_hit_o
);
    logic       rst_sync1_reg;
    logic       rst_sync2_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       hit_reg;
    logic [NUM_SUPPLIES-1:0] supply_flag;
    logic [NUM_FANS-1:0]     stall_flag;
    logic zone_one_flag;
    logic zone_two_flag;
    logic zone_three_flag;
    logic v12_flag;
    logic rd_one;
    logic rd_two;
    logic sel_one;
    logic sel_two;
    byte_t status_one;
    byte_t status_two;

    fault_bits_if one_bits ();
    fault_bits_if two_bits ();

    // unsigned window with inclusive low edge
    function automatic logic out_incl(input logic [7:0] v, input logic [7:0] lo,
                                      input logic [7:0] hi);
        return (v <= lo) || (v > hi);
    endfunction

    // signed window with inclusive low edge
    function automatic logic out_signed(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
        return ($signed(v) <= $signed(lo)) || ($signed(v) > $signed(hi));
    endfunction

    // reset release through two flops
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end

    // supply and fan comparisons
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SUPPLIES; gi++) begin : g_sup
            assign supply_flag[gi] = out_incl(supply_val_i[gi], supply_low_i[gi],
                                              supply_high_i[gi]);
        end
        for (gi = 0; gi < NUM_FANS; gi++) begin : g_fan
            assign stall_flag[gi] = tach_count_i[gi] > tach_min_i[gi];
        end
    endgenerate

    // temperature zones and the strict 12V window
    assign zone_one_flag   = out_signed(temp_one_i, zone_one_low_i, zone_one_high_i)
                             | diode_one_fault_i;
    assign zone_two_flag   = out_signed(temp_die_i, zone_two_low_i, zone_two_high_i);
    assign zone_three_flag = out_signed(temp_two_i, zone_three_low_i, zone_three_high_i)
                             | diode_two_fault_i;
    assign v12_flag        = (v12_val_i < v12_low_i) || (v12_val_i > v12_high_i);

    // read decode; writes are never decoded into state
    assign sel_one = reg_addr_i == STATUS_ONE_ADDR;
    assign sel_two = reg_addr_i == STATUS_TWO_ADDR;
    assign rd_one  = reg_rd_i & sel_one;
    assign rd_two  = reg_rd_i & sel_two;

    // condition vector for status two
    assign two_bits.cond = {diode_two_fault_i, diode_one_fault_i,
                            stall_flag, 1'b0, v12_flag};
    assign two_bits.rd_clear = rd_two;

    // condition vector for status one, summary bit forced separately
    assign one_bits.cond = {1'b0, zone_three_flag, zone_two_flag, zone_one_flag,
                            supply_flag};
    assign one_bits.rd_clear = rd_one;

    sticky_byte #(
        .KEEP_MASK (8'h7F)
    ) u_one (
        .clk_i   (ref_clk_i),
        .rst_n_i (rst_sync2_reg),
        .bits    (one_bits)
    );

    sticky_byte #(
        .KEEP_MASK (8'hFD)
    ) u_two (
        .clk_i   (ref_clk_i),
        .rst_n_i (rst_sync2_reg),
        .bits    (two_bits)
    );

    // summary bit mirrors status two
    assign status_two = two_bits.status;
    assign status_one = {|status_two, one_bits.status[6:0]};

    // read data mux; other addresses keep the last data, writes ignored
    assign rdata_next = rd_one ? status_one :
                        rd_two ? status_two : rdata_reg;

    // read data register
    always_ff @(posedge ref_clk_i or negedge rst_sync2_reg) begin
        if (!rst_sync2_reg) begin
            rdata_reg <= STATUS_RESET;
            hit_reg   <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            hit_reg   <= rd_one | rd_two;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign reg_hit_o   = hit_reg;

endmodule
`default_nettype wire

// File: tb/fault_status_latch_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fault_status_latch_assertions (
    // watched ports
    input wire logic       ref_clk_i,
    input wire logic       nrst_i,
    input wire logic [7:0] v12_val_i,
    input wire logic [7:0] v12_low_i,
    input wire logic       diode_one_fault_i,
    input wire logic       diode_two_fault_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       reg_hit_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // status reads by address
    wire rd_one = reg_rd_i && reg_addr_i == 8'h41;
    wire rd_two = reg_rd_i && reg_addr_i == 8'h42;
    // fault held over a read
    sequence s_d1(rd); diode_one_fault_i ##1 diode_one_fault_i && rd; endsequence
    sequence s_d2; diode_two_fault_i ##1 diode_two_fault_i && rd_one; endsequence
    sequence s_lo; v12_val_i < v12_low_i ##1 v12_val_i < v12_low_i && rd_two; endsequence
    a_hit_on_read: assert property (rd_one || rd_two |=> reg_hit_o)
        else $error("no hit after status read");
    a_no_stray_hit: assert property (!(rd_one || rd_two) |=> !reg_hit_o)
        else $error("hit without status read");
    a_rdata_kept: assert property (!(rd_one || rd_two) |=> $stable(reg_rdata_o))
        else $error("read data moved without read");
    a_rsvd_zero: assert property (rd_two |=> reg_rdata_o[1] == 1'b0)
        else $error("reserved bit set");
    a_diode_one_two: assert property (s_d1(rd_two) |=> reg_rdata_o[6])
        else $error("diode one flag missing");
    a_diode_one_zone: assert property (s_d1(rd_one) |=> reg_rdata_o[4])
        else $error("zone one flag missing");
    a_diode_two_sum: assert property (s_d2 |=> reg_rdata_o[7:6] == 2'b11)
        else $error("diode two or summary missing");
    a_v12_below: assert property (s_lo |=> reg_rdata_o[0])
        else $error("12V low flag missing");
endmodule
bind fault_status_latch fault_status_latch_assertions u_chk (.ref_clk_i, .nrst_i,
    .v12_val_i, .v12_low_i, .diode_one_fault_i, .diode_two_fault_i, .reg_addr_i,
    .reg_rd_i, .reg_rdata_o, .reg_hit_o);
`default_nettype wire

// File: tb/fault_host.sv
`timescale 1ns/1ps
`default_nettype none
module fault_host
    import fault_status_pkg::*;
(
    // clock and read data
    input  wire logic  clk_i,
    input  wire byte_t rdata_i,
    // register requests
    output logic [7:0] addr_o = 8'h00,
    output logic       rd_o = 1'b0,
    output logic       wr_o = 1'b0,
    output logic [7:0] wdata_o = 8'h00
);
    // one read, data taken once the answer settles
    task automatic rd_reg(input byte_t a, output byte_t d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(negedge clk_i);
        d = rdata_i;
    endtask
    // one write, ignored by the status block
    task automatic wr_reg(input byte_t a, input byte_t v);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= v;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: tb/fault_status_latch_test.sv
`timescale 1ns/1ps
`default_nettype none
module fault_status_latch_test
    import fault_status_pkg::*;
;
    // design inputs, all faults quiet
    logic ref_clk_i = 1'b0, nrst_i = 1'b0, diode_one_fault_i = 1'b0, diode_two_fault_i = 1'b0;
    logic [3:0][7:0] supply_val_i = {4{8'hC0}}, supply_low_i = {4{8'h10}};
    logic [3:0][7:0] supply_high_i = {4{8'hF0}};
    logic [7:0] v12_val_i = 8'hC0, v12_low_i = 8'h40, v12_high_i = 8'hF0;
    logic [7:0] temp_one_i = 8'h10, temp_die_i = 8'h10, temp_two_i = 8'h10;
    logic [7:0] zone_one_low_i = 8'hCE, zone_two_low_i = 8'h81, zone_three_low_i = 8'hCE;
    logic [7:0] zone_one_high_i = 8'h40, zone_two_high_i = 8'h40, zone_three_high_i = 8'h40;
    logic [3:0][15:0] tach_count_i = '0, tach_min_i = {4{16'h8000}};
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic reg_rd_i, reg_wr_i, reg_hit_o;
    byte_t d;
    int err_count = 0, checked = 0, cyc = 0;
    fault_status_latch u_dut (.*);
    fault_host u_host (.clk_i(ref_clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
        .rd_o(reg_rd_i), .wr_o(reg_wr_i), .wdata_o(reg_wdata_i));
    // clock and hang guard
    always #10 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic cmp(input byte_t g, input byte_t e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rd_chk(input byte_t a, input byte_t e);
        u_host.rd_reg(a, d);
        cmp(d, e);
        cmp({7'h00, reg_hit_o}, {7'h00, (a == 8'h41) || (a == 8'h42)});
    endtask
    task automatic t_reset();
        repeat (20) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        rd_chk(8'h41, 8'h00);
        rd_chk(8'h42, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_supply();
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk_i) supply_val_i[i] <= 8'h10;
            @(posedge ref_clk_i) supply_val_i[i] <= 8'hF0;
            rd_chk(8'h41, 8'h01 << i);
            rd_chk(8'h41, 8'h00);
            @(posedge ref_clk_i) supply_val_i[i] <= 8'hF1;
            @(posedge ref_clk_i) supply_val_i[i] <= 8'hC0;
            rd_chk(8'h41, 8'h01 << i);
            rd_chk(8'h41, 8'h00);
        end
        $display("t_supply done");
    endtask
    task automatic t_temp();
        @(posedge ref_clk_i) {temp_one_i, temp_die_i, temp_two_i} <= 24'hCE41CE;
        rd_chk(8'h41, 8'h70);
        @(posedge ref_clk_i) {temp_one_i, temp_die_i, temp_two_i} <= 24'h104010;
        rd_chk(8'h41, 8'h70);
        rd_chk(8'h41, 8'h00);
        $display("t_temp done");
    endtask
    task automatic t_two();
        @(posedge ref_clk_i);
        v12_val_i         <= 8'h3F; // just below low
        diode_one_fault_i <= 1'b1;
        tach_count_i[2]   <= 16'h8001; // just above minimum
        rd_chk(8'h41, 8'h90);
        rd_chk(8'h42, 8'h51);
        @(posedge ref_clk_i);
        v12_val_i         <= 8'h40; // equal to low: strict, no flag
        diode_one_fault_i <= 1'b0;
        tach_count_i[2]   <= 16'h8000; // equal to minimum: no stall
        rd_chk(8'h41, 8'h90);
        rd_chk(8'h42, 8'h51);
        rd_chk(8'h42, 8'h00);
        rd_chk(8'h41, 8'h00);
        $display("t_two done");
    endtask
    task automatic t_race();
        fork
            u_host.rd_reg(8'h42, d);
            begin
                @(posedge ref_clk_i) diode_two_fault_i <= 1'b1;
                @(posedge ref_clk_i) diode_two_fault_i <= 1'b0;
            end
        join
        cmp(d, 8'h00);
        rd_chk(8'h42, 8'h80);
        rd_chk(8'h41, 8'h40);
        rd_chk(8'h41, 8'h00);
        @(posedge ref_clk_i) diode_two_fault_i <= 1'b1;
        rd_chk(8'h41, 8'h C0);
        @(posedge ref_clk_i) diode_two_fault_i <= 1'b0;
        rd_chk(8'h42, 8'h80);
        rd_chk(8'h41, 8'h40);
        $display("t_race done");
    endtask
    task automatic t_write();
        @(posedge ref_clk_i) supply_val_i[0] <= 8'h00;
        @(posedge ref_clk_i) supply_val_i[0] <= 8'hC0;
        u_host.wr_reg(8'h41, 8'h00);
        u_host.wr_reg(8'h42, 8'hFF);
        rd_chk(8'h42, 8'h00);
        rd_chk(8'h41, 8'h01);
        rd_chk(8'h43, 8'h01);
        $display("t_write done");
    endtask
    task automatic report_and_stop();
        $display("checked %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        t_reset();
        t_supply();
        t_temp();
        t_two();
        t_race();
        t_write();
        report_and_stop();
    end
endmodule
`default_nettype wire
